// ===== rtl/xsd_line_ctrl.sv
/*
 * Four-port line control and steady-state detector top.
 * Assumes line inputs and the receive clocks arrive asynchronously and
 * registers are reached over a plain strobe port with one-cycle read data.
 */
`timescale 1ns/1ps
module xsd_line_ctrl
	import xsd_pkg::*;
#(
	parameter int PORTS = NUM_PORTS
)
(
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic [PORTS-1:0] TXD_CTRL_I,
	input wire logic [PORTS-1:0] RXD_I,
	input wire logic [PORTS-1:0] RXCLK_I,
	input wire logic [PORTS-1:0] CTS_I,
	input wire logic [1:0] DSR_IRQ_I,
	output logic [PORTS-1:0] TXD_O,
	output logic [PORTS-1:0] TXD_OE_O,
	output logic [PORTS-1:0] CTS_SEEN_O,
	output logic PORT01_INTERRUPT_LINE_O,
	output logic PORT23_INTERRUPT_LINE_O
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [PORTS-1:0] rxd_s1_q, rxd_s2_q, clk_s1_q, clk_s2_q, clk_s3_q, cts_s1_q, cts_s2_q;
	logic [1:0] dsr_s1_q, dsr_s2_q;

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			rxd_s1_q <= '0;
			rxd_s2_q <= '0;
			clk_s1_q <= '0;
			clk_s2_q <= '0;
			clk_s3_q <= '0;
			cts_s1_q <= '0;
			cts_s2_q <= '0;
			dsr_s1_q <= 2'h0;
			dsr_s2_q <= 2'h0;
		end else begin
			rxd_s1_q <= RXD_I;
			rxd_s2_q <= rxd_s1_q;
			clk_s1_q <= RXCLK_I;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			cts_s1_q <= CTS_I;
			cts_s2_q <= cts_s1_q;
			dsr_s1_q <= DSR_IRQ_I;
			dsr_s2_q <= dsr_s1_q;
		end
	end

	// Data settles long before the clock falls, so the synced data is used as-is
	logic [PORTS-1:0] fall;
	assign fall = clk_s3_q & ~clk_s2_q;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	function automatic logic hit_bank(input logic [3:0] addr, input logic [3:0] base, input int n);
		hit_bank = (addr >= base) && (addr < base + 4'(n));
	endfunction

	logic [1:0] drv_q [PORTS], drv_d [PORTS];
	logic [2:0] det_q [PORTS], det_d [PORTS];
	logic [PORTS-1:0] clr;
	logic [3:0] code [PORTS];
	logic [PORTS-1:0] ovf, cts_seen;
	logic [7:0] rdata_d, rdata_q;
	logic [1:0] pidx;

	assign pidx = ADDR_I[1:0];

	always_comb begin
		for (int i = 0; i < PORTS; i++) begin
			drv_d[i] = drv_q[i];
			det_d[i] = det_q[i];
			clr[i] = 1'b0;
		end
		rdata_d = 8'h00;
		if (WR_I && hit_bank(ADDR_I, DRV_CTRL_BASE, PORTS)) begin
			drv_d[pidx] = WDATA_I[1:0];
		end else if (WR_I && hit_bank(ADDR_I, DET_CTRL_BASE, PORTS)) begin
			det_d[pidx] = WDATA_I[2:0];
		end else if (WR_I && hit_bank(ADDR_I, DET_STAT_BASE, PORTS)) begin
			clr[pidx] = |WDATA_I[4:0];
		end
		if (RD_I && hit_bank(ADDR_I, DRV_CTRL_BASE, PORTS)) begin
			rdata_d = {6'h00, drv_q[pidx]};
		end else if (RD_I && hit_bank(ADDR_I, DET_CTRL_BASE, PORTS)) begin
			rdata_d = {5'h00, det_q[pidx]};
		end else if (RD_I && hit_bank(ADDR_I, DET_STAT_BASE, PORTS)) begin
			rdata_d = {3'h0, ovf[pidx], code[pidx]};
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			for (int i = 0; i < PORTS; i++) begin
				drv_q[i] <= DRV_CTRL_RST;
				det_q[i] <= DET_CTRL_RST;
			end
			rdata_q <= 8'h00;
		end else begin
			for (int i = 0; i < PORTS; i++) begin
				drv_q[i] <= drv_d[i];
				det_q[i] <= det_d[i];
			end
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Per-port detectors
	// ----------------------------------------
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		xsd_port_detect u_det (
			.clk_i(CLOCK_I),
			.rst_n_i(RESET_N_I),
			.fall_i(fall[p]),
			.rxd_i(rxd_s2_q[p]),
			.cts_raw_i(cts_s2_q[p]),
			.det_en_i(det_q[p][DET_ENABLE_BIT]),
			.cts_hold_i(det_q[p][DET_CTS_HOLD_BIT]),
			.stat_clr_i(clr[p]),
			.cts_seen_o(cts_seen[p]),
			.code_o(code[p]),
			.ovf_o(ovf[p])
		);
	end

	// ----------------------------------------
	// Outputs and interrupt lines
	// ----------------------------------------
	logic [PORTS-1:0] txd_d, txd_q, oe_d, oe_q, cts_q, req;
	logic irq01_d, irq01_q, irq23_d, irq23_q;

	always_comb begin
		for (int i = 0; i < PORTS; i++) begin
			// Zeros keep the line in a defined X.21 idle while the controller is gated off
			txd_d[i] = TXD_CTRL_I[i] & drv_q[i][DRV_TXD_EN_BIT];
			oe_d[i] = drv_q[i][DRV_OUT_EN_BIT];
			req[i] = det_q[i][DET_INT_EN_BIT] && (code[i] != CODE_NONE);
		end
		// Plain OR of live levels, nothing latched here
		irq01_d = req[0] | req[1] | dsr_s2_q[0];
		irq23_d = req[2] | req[3] | dsr_s2_q[1];
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			txd_q <= '0;
			oe_q <= '0;
			cts_q <= '0;
			irq01_q <= 1'b0;
			irq23_q <= 1'b0;
		end else begin
			txd_q <= txd_d;
			oe_q <= oe_d;
			cts_q <= cts_seen;
			irq01_q <= irq01_d;
			irq23_q <= irq23_d;
		end
	end

	assign RDATA_O = rdata_q;
	assign TXD_O = txd_q;
	assign TXD_OE_O = oe_q;
	assign CTS_SEEN_O = cts_q;
	assign PORT01_INTERRUPT_LINE_O = irq01_q;
	assign PORT23_INTERRUPT_LINE_O = irq23_q;

endmodule

// ===== rtl/xsd_pkg.sv
/*
 * Shared constants for the four-port steady-state detector and line control.
 * Assumes a single 20 MHz register clock and a plain register port.
 */
package xsd_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NUM_PORTS = 4;
	localparam int STEADY_BITS = 16;
	localparam logic [4:0] STEADY_COUNT = 5'h10;

	// ----------------------------------------
	// Register offsets (word index)
	// ----------------------------------------
	localparam logic [3:0] DRV_CTRL_BASE = 4'h0;
	localparam logic [3:0] DET_CTRL_BASE = 4'h4;
	localparam logic [3:0] DET_STAT_BASE = 4'h8;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DRV_OUT_EN_BIT = 0;
	localparam int DRV_TXD_EN_BIT = 1;
	localparam int DET_ENABLE_BIT = 0;
	localparam int DET_INT_EN_BIT = 1;
	localparam int DET_CTS_HOLD_BIT = 2;
	localparam int STAT_OVF_BIT = 4;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [1:0] DRV_CTRL_RST = 2'h0;
	localparam logic [2:0] DET_CTRL_RST = 3'h0;
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_ZEROS = 4'h1;
	localparam logic [3:0] CODE_ONES = 4'h2;
	localparam logic [3:0] CODE_ALT = 4'h3;

	typedef enum logic [1:0] {
		PAT_NONE,
		PAT_ZEROS,
		PAT_ONES,
		PAT_ALT
	} xsd_pat_t;

endpackage

// ===== rtl/xsd_port_detect.sv
/*
 * One port of the steady-state detector: CTS hold filter, pattern timing
 * and sticky status code. Assumes sampled line levels and a one-cycle
 * falling-edge strobe of the receive clock from the same clock domain.
 */
`timescale 1ns/1ps
module xsd_port_detect
	import xsd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic fall_i,
	input wire logic rxd_i,
	input wire logic cts_raw_i,
	input wire logic det_en_i,
	input wire logic cts_hold_i,
	input wire logic stat_clr_i,
	output logic cts_seen_o,
	output logic [3:0] code_o,
	output logic ovf_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	xsd_pat_t pat_q, pat_d;
	logic [4:0] cnt_q, cnt_d;
	logic [4:0] hcnt_q, hcnt_d;
	logic cts_q, cts_d;
	logic prev_q, prev_d;
	logic armed_q, armed_d;
	logic [3:0] code_q, code_d;
	logic ovf_q, ovf_d;

	always_comb begin
		xsd_pat_t cand;
		logic hit;
		cand = PAT_NONE;
		hit = 1'b0;
		pat_d = pat_q;
		cnt_d = cnt_q;
		hcnt_d = hcnt_q;
		cts_d = cts_q;
		prev_d = prev_q;
		armed_d = armed_q;
		code_d = code_q;
		ovf_d = ovf_q;
		if (fall_i) begin
			// Hold filter: flip only after a full steady run of the opposite level
			if (cts_raw_i == cts_q) begin
				hcnt_d = 5'h0;
			end else if (hcnt_q == STEADY_COUNT - 5'h1) begin
				cts_d = cts_raw_i;
				hcnt_d = 5'h0;
			end else begin
				hcnt_d = hcnt_q + 5'h1;
			end
			prev_d = rxd_i;
			// Candidate pattern given the previous bit
			if (cnt_q != 5'h0 && rxd_i != prev_q && pat_q != PAT_ONES && pat_q != PAT_ZEROS) begin
				cand = PAT_ALT;
			end else if (cnt_q != 5'h0 && rxd_i == prev_q && pat_q != PAT_ALT) begin
				cand = rxd_i ? PAT_ONES : PAT_ZEROS;
			end
			if (cts_seen_o || !det_en_i) begin
				cnt_d = 5'h0;
				pat_d = PAT_NONE;
				armed_d = 1'b1;
			end else if (cnt_q == 5'h0 || cnt_q == 5'h1 || cand == PAT_NONE || (pat_q != cand && cnt_q > 5'h1)) begin
				// Pattern broken: restart with this bit as the first; a second bit sets the pattern and counts two
				cnt_d = (cnt_q == 5'h1 && cand != PAT_NONE) ? 5'h2 : 5'h1;
				pat_d = (cnt_q == 5'h1) ? cand : PAT_NONE;
				armed_d = 1'b1;
			end else if (cnt_q < STEADY_COUNT) begin
				cnt_d = cnt_q + 5'h1;
			end
			if (det_en_i && !cts_seen_o && armed_q && cnt_d == STEADY_COUNT) begin
				hit = 1'b1;
				armed_d = 1'b0;
			end
		end
		if (hit) begin
			if (stat_clr_i) begin
				// A clear in the same cycle still drops the old overflow
				ovf_d = 1'b0;
			end else if (code_q != CODE_NONE) begin
				ovf_d = 1'b1;
			end
			case (pat_d)
				PAT_ZEROS: code_d = CODE_ZEROS;
				PAT_ONES: code_d = CODE_ONES;
				PAT_ALT: code_d = CODE_ALT;
				default: code_d = CODE_NONE;
			endcase
		end else if (stat_clr_i || !det_en_i) begin
			// Counter is left running across the clear
			code_d = CODE_NONE;
			ovf_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pat_q <= PAT_NONE;
			cnt_q <= 5'h0;
			hcnt_q <= 5'h0;
			cts_q <= 1'b0;
			prev_q <= 1'b0;
			armed_q <= 1'b1;
			code_q <= CODE_NONE;
			ovf_q <= 1'b0;
		end else begin
			pat_q <= pat_d;
			cnt_q <= cnt_d;
			hcnt_q <= hcnt_d;
			cts_q <= cts_d;
			prev_q <= prev_d;
			armed_q <= armed_d;
			code_q <= code_d;
			ovf_q <= ovf_d;
		end
	end

	// Filtered level tracks the raw level directly when hold is off
	assign cts_seen_o = cts_hold_i ? cts_q : cts_raw_i;
	assign code_o = code_q;
	assign ovf_o = ovf_q;

endmodule

// ===== tb/xsd_line_ctrl_sva.sv
/* Port-level checker for the line control top.
 * Assumes it is bound to the top module and that the package is compiled. */
`timescale 1ns/1ps
module xsd_line_ctrl_sva
	import xsd_pkg::*;
#(
	parameter int PORTS = NUM_PORTS
)
(
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic [PORTS-1:0] TXD_CTRL_I,
	input wire logic [1:0] DSR_IRQ_I,
	input wire logic [PORTS-1:0] TXD_O,
	input wire logic [PORTS-1:0] TXD_OE_O,
	input wire logic PORT01_INTERRUPT_LINE_O,
	input wire logic PORT23_INTERRUPT_LINE_O
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESET_N_I);
	a_reset_drv_off: assert property ($rose(RESET_N_I) |-> TXD_OE_O == '0)
		else $error("driver enabled after reset");
	a_txd_gated: assert property ((TXD_O & ~$past(TXD_CTRL_I)) == '0)
		else $error("transmit data not from controller");
	a_oe_write: assert property (WR_I && ADDR_I < 4'h4 |-> ##2 TXD_OE_O[$past(ADDR_I[1:0], 2)] == $past(WDATA_I[0], 2))
		else $error("driver enable missed write");
	a_oe_hold: assert property (!$stable(TXD_OE_O) |-> $past(WR_I, 2) && $past(ADDR_I, 2) < 4'h4)
		else $error("driver enable moved without write");
	a_oe_readback: assert property (RD_I && ADDR_I < 4'h4 |=> RDATA_O[0] == TXD_OE_O[$past(ADDR_I[1:0])])
		else $error("driver enable readback differs");
	a_status_code: assert property (RD_I && ADDR_I[3:2] == 2'h2 |=> RDATA_O[3:0] <= 4'h3 && RDATA_O[7:5] == 3'h0)
		else $error("bad status code");
	a_dsr01_line: assert property (DSR_IRQ_I[0] [*5] |-> PORT01_INTERRUPT_LINE_O)
		else $error("pair 01 line ignores DSR");
	a_dsr23_line: assert property (DSR_IRQ_I[1] [*5] |-> PORT23_INTERRUPT_LINE_O)
		else $error("pair 23 line ignores DSR");
	c_ovf: cover property (RD_I && ADDR_I[3:2] == 2'h2 ##1 RDATA_O[4]);
	c_irq01: cover property ($rose(PORT01_INTERRUPT_LINE_O));
	c_irq23: cover property ($rose(PORT23_INTERRUPT_LINE_O));
endmodule

bind xsd_line_ctrl xsd_line_ctrl_sva #(.PORTS(PORTS)) i_sva (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.TXD_CTRL_I(TXD_CTRL_I), .DSR_IRQ_I(DSR_IRQ_I), .TXD_O(TXD_O), .TXD_OE_O(TXD_OE_O),
	.PORT01_INTERRUPT_LINE_O(PORT01_INTERRUPT_LINE_O), .PORT23_INTERRUPT_LINE_O(PORT23_INTERRUPT_LINE_O));

// ===== tb/xsd_line_model.sv
/* Far-end line model: one receive clock and data line for all ports.
 * Assumes the bench gates the clock per frame and picks the pattern. */
`timescale 1ns/1ps
module xsd_line_model (
	input wire logic run_i,
	input wire logic [1:0] mode_i,
	output logic rxclk_o,
	output logic rxd_o
);
	// ------------------------------
	// Clock stands still between frames
	// ------------------------------
	initial begin
		rxclk_o = 1'b0;
		rxd_o = 1'b0;
		#37;
		forever begin
			#200;
			if (run_i || rxclk_o) rxclk_o = ~rxclk_o;
		end
	end
	// New bit on the rise, settled at the sampling fall
	always @(posedge rxclk_o) begin
		rxd_o <= (mode_i == 2'h2) ? ~rxd_o : mode_i[0];
	end
endmodule

// ===== tb/xsd_line_ctrl_test.sv
/* Self-checking bench for the line control and pattern detector.
 * Assumes the line model drives every receive port alike. */
`timescale 1ns/1ps
module xsd_line_ctrl_test;
	import xsd_pkg::*;
	// ------------------------------
	// Signals and tasks
	// ------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_q = 1'b0;
	logic run = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [3:0] txd_ctrl = 4'h0;
	logic [3:0] cts = 4'h0;
	logic [1:0] dsr = 2'h0;
	logic rxclk, rxd;
	logic [7:0] rdata;
	logic [3:0] txd, txd_oe, cts_seen;
	logic [1:0] irq;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000_3226;
	logic [3:0] codes[3] = '{CODE_ZEROS, CODE_ONES, CODE_ALT};
	int errors = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	xsd_line_model i_line (.run_i(run), .mode_i(mode), .rxclk_o(rxclk), .rxd_o(rxd));
	xsd_line_ctrl i_dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .TXD_CTRL_I(txd_ctrl), .RXD_I({4{rxd}}), .RXCLK_I({4{rxclk}}),
		.CTS_I(cts), .DSR_IRQ_I(dsr), .TXD_O(txd), .TXD_OE_O(txd_oe), .CTS_SEEN_O(cts_seen),
		.PORT01_INTERRUPT_LINE_O(irq[0]), .PORT23_INTERRUPT_LINE_O(irq[1]));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Expected value queued now, compared when the data stands
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic bits(input int n);
		run <= 1'b1;
		repeat (n * 8) @(posedge clk);
		run <= 1'b0;
		repeat (12) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk) begin
		if (rd_q === 1'b1) check(rdata, exp_q.pop_front(), "read data");
	end
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	// ------------------------------
	// Scenarios
	// ------------------------------
	initial begin
		logic [31:0] r;
		int n;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) rd_reg(4'(a), 8'h00);
		for (int p = 0; p < 4; p++) begin
			r = rnd();
			txd_ctrl <= r[7:4];
			wr_reg(4'(p), {6'h00, r[1:0]});
			rd_reg(4'(p), {6'h00, r[1:0]});
			@(negedge clk);
			check(8'(txd_oe[p]), 8'(r[0]), "driver enable");
			check(8'(txd[p]), 8'(r[1] & r[p + 4]), "transmit data");
		end
		for (int p = 0; p < 4; p++) wr_reg(4'(p), 8'h03);
		@(negedge clk);
		check(8'(txd_oe), 8'h0F, "driver enable");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(8'(txd_oe), 8'h00, "driver enable");
		rst_n <= 1'b1;
		$display("driver control done");
		for (int p = 0; p < 4; p++) begin
			n = (p + 1) % 3;
			mode <= 2'(p % 3);
			cts[p] <= 1'b1;
			wr_reg(4'(4 + p), 8'h03);
			bits(20);
			rd_reg(4'(8 + p), 8'h00);
			cts[p] <= 1'b0;
			bits(20);
			rd_reg(4'(8 + p), {4'h0, codes[p % 3]});
			@(negedge clk);
			check(8'(irq), 8'(p < 2 ? 1 : 2), "interrupt lines");
			wr_reg(4'(8 + p), 8'h01);
			bits(20);
			rd_reg(4'(8 + p), 8'h00);
			@(negedge clk);
			check(8'(irq), 8'h00, "interrupt lines");
			cts[p] <= 1'b1;
			bits(2);
			cts[p] <= 1'b0;
			bits(20);
			rd_reg(4'(8 + p), {4'h0, codes[p % 3]});
			mode <= 2'(n);
			bits(20);
			rd_reg(4'(8 + p), {4'h1, codes[n]});
			wr_reg(4'(4 + p), 8'h01);
			rd_reg(4'(8 + p), {4'h1, codes[n]});
			@(negedge clk);
			check(8'(irq), 8'h00, "interrupt lines");
			wr_reg(4'(4 + p), 8'h00);
			rd_reg(4'(8 + p), 8'h00);
			$display("detection on port %0d done", p);
		end
		wr_reg(4'h4, 8'h04);
		cts[0] <= 1'b1;
		bits(8);
		@(negedge clk);
		check(8'(cts_seen[0]), 8'h00, "held indication");
		bits(12);
		@(negedge clk);
		check(8'(cts_seen[0]), 8'h01, "held indication");
		dsr <= 2'h3;
		repeat (8) @(posedge clk);
		@(negedge clk);
		check(8'(irq), 8'h03, "interrupt lines");
		dsr <= 2'h0;
		$display("hold and shared lines done");
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule
